// ---- src/shdlc_link_endpoint.v ----
// Sliding-window link endpoint: establishment, acknowledgement, reject and timers.
// Functional notes
// - Bring-up starts by sending RSET.
// - Link reset drops all buffered frames.
// - Every link reset pulses an upper-layer indication.
// - Acceptable RSET answered by UA; UA establishes.
// - Before establishment only RSET is accepted, plus UA while waiting.
// - Connection timer expiry resends RSET.
// - Crossed RSETs: both answer UA.
// - Too-large window offer: own RSET, no UA.
// - Idle receiver sends RR on acknowledge timeout.
// - Acknowledge timer starts on first unacknowledged frame.
// - Sending a numbered frame stops acknowledge timer.
// - Sequence gap sends REJ promptly.
// - Guard timeout retransmits unacknowledged frames.
// - Last frame acknowledged by RR, never rejected.
// - RNR acknowledges and suspends peer sending.
// - Resuming RR repeated every TRR until I-frame.
// - RR after RNR with nothing queued: empty I-frame.
// - One-ahead frame with SREJ: buffer, send SREJ.
// - Missing frame delivered, then buffered frame.
// - Sequence arithmetic wraps modulo eight.
// - SREJ resends exactly one frame.
// - Acknowledge time scales with window over four.
// - Guard time at least ten milliseconds.
// - Connection time at most five milliseconds.
// - Counters zeroed on establishment.
`timescale 1ns/1ns
`default_nettype none
`include "shdlc_link_regs.vh"
module shdlc_link_endpoint #(
   parameter [`TMR_W-1:0] T1_CYC = `T1_US * `CLK_MHZ,
   parameter [`TMR_W-1:0] T2_CYC = `T2_US * `CLK_MHZ,
   parameter [`TMR_W-1:0] T3_CYC = `T3_US * `CLK_MHZ,
   parameter [`TMR_W-1:0] TRR_CYC = `TRR_US * `CLK_MHZ
) (
   input wire clk_sys_i,
   input wire nrst_i,
   input wire link_start_i,
   input wire [2:0] cfg_win_i,
   input wire cfg_srej_i,
   input wire local_busy_i,
   input wire rx_valid_i,
   input wire [7:0] rx_ctrl_i,
   input wire [7:0] rx_tag_i,
   input wire rx_has_cfg_i,
   input wire [2:0] rx_win_i,
   input wire rx_srej_i,
   input wire up_valid_i,
   input wire [7:0] up_tag_i,
   output wire up_ready_o,
   output wire tx_valid_o,
   input wire tx_ready_i,
   output wire [7:0] tx_ctrl_o,
   output wire [7:0] tx_tag_o,
   output wire tx_empty_o,
   output wire tx_cfg_o,
   output wire [2:0] tx_win_o,
   output wire tx_srej_o,
   output wire dlv_valid_o,
   output wire [7:0] dlv_tag_o,
   output wire link_up_o,
   output wire link_reset_o
);
   // ****************************************
   // State
   // ****************************************
   reg [1:0] st_reg;
   reg [2:0] win_reg, ns_reg, vr_reg, dnr_reg, head_reg, rsnd_n_reg, sbuf_n_reg;
   reg srej_neg_reg, peer_busy_reg, busy_q_reg, resume_reg, ack_run_reg;
   reg ua_pend_reg, rset_pend_reg, rej_pend_reg, srej_pend_reg, rnr_pend_reg;
   reg rr_pend_reg, rsnd_pend_reg, empty_pend_reg, rej_sent_reg, sbuf_vld_reg, dlv2_reg;
   reg [7:0] sbuf_tag_reg, dlv_tag_reg, tx_ctrl_reg, tx_tag_reg;
   reg dlv_valid_reg, link_reset_reg, tx_valid_reg, tx_empty_reg, tx_cfg_reg, tx_srej_reg;
   reg [2:0] tx_win_reg;
   reg [`NTMR-1:0] tmr_rst_reg;
   reg [7:0] q_tag [0:7];
   reg q_emp [0:7];
   wire [`NTMR-1:0] tmr_run, tmr_exp;
   wire [`NTMR*`TMR_W-1:0] tmr_lim;
   // ****************************************
   // Receive decode
   // ****************************************
   wire is_up = (st_reg == `ST_UP);
   wire rx_i = rx_valid_i && (rx_ctrl_i[7:6] == `I_TAG);
   wire rx_s = rx_valid_i && (rx_ctrl_i[7:5] == `S_TAG);
   wire rx_u = rx_valid_i && (rx_ctrl_i[7:5] == `U_TAG);
   wire [2:0] rx_ns = rx_ctrl_i[5:3];
   wire [2:0] rx_nr = rx_ctrl_i[2:0];
   wire [1:0] rx_ty = rx_ctrl_i[4:3];
   wire is_rset = rx_u && (rx_ctrl_i[4:0] == `U_RSET);
   wire is_ua = rx_u && (rx_ctrl_i[4:0] == `U_UA);
   wire [2:0] off_win = rx_has_cfg_i ? rx_win_i : `DEF_WIN;
   wire rset_ok = (off_win <= cfg_win_i);
   wire go_up = (is_rset && rset_ok) || (is_ua && st_reg == `ST_WAIT);
   // Acknowledged number must lie between oldest outstanding and newest queued.
   wire [2:0] nr_off = rx_nr - dnr_reg;
   wire [2:0] hd_off = head_reg - dnr_reg;
   wire ack_ok = is_up && (nr_off <= hd_off);
   wire acks = rx_i || (rx_s && rx_ty != `S_SREJ);
   wire ack_adv = ack_ok && acks && (rx_nr != dnr_reg);
   wire [2:0] vr_nx = vr_reg + `SEQ_ONE;
   wire room = is_up && (hd_off < win_reg);
   wire push = up_valid_i && room;
   wire tx_free = !tx_valid_reg || tx_ready_i;
   // ****************************************
   // Timers
   // ****************************************
   wire [26:0] ack_prod = (T1_CYC >> 2) * win_reg;
   assign tmr_lim = {TRR_CYC, T3_CYC, T2_CYC, ack_prod[`TMR_W-1:0]};
   assign tmr_run[`TMR_ACK] = ack_run_reg;
   assign tmr_run[`TMR_GRD] = is_up && (dnr_reg != ns_reg);
   assign tmr_run[`TMR_CON] = (st_reg == `ST_WAIT);
   assign tmr_run[`TMR_RR] = resume_reg;
   genvar g;
   generate
      for (g = 0; g < `NTMR; g = g + 1) begin : tmr
         reg [`TMR_W-1:0] cnt_reg;
         wire [`TMR_W-1:0] lim = tmr_lim[g*`TMR_W +: `TMR_W];
         assign tmr_exp[g] = tmr_run[g] && !tmr_rst_reg[g] && (cnt_reg == lim - 1'b1);
         always @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
               cnt_reg <= {`TMR_W{1'b0}};
            end else if (!tmr_run[g] || tmr_rst_reg[g] || tmr_exp[g]) begin
               cnt_reg <= {`TMR_W{1'b0}};
            end else begin
               cnt_reg <= cnt_reg + 1'b1;
            end
         end
      end
   endgenerate
   // ****************************************
   // Main control
   // ****************************************
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= `ST_DOWN;
         win_reg <= `DEF_WIN;
         ns_reg <= `SEQ_ZERO;
         vr_reg <= `SEQ_ZERO;
         dnr_reg <= `SEQ_ZERO;
         head_reg <= `SEQ_ZERO;
         rsnd_n_reg <= `SEQ_ZERO;
         sbuf_n_reg <= `SEQ_ZERO;
         {srej_neg_reg, peer_busy_reg, busy_q_reg, resume_reg, ack_run_reg} <= 5'h0;
         {ua_pend_reg, rset_pend_reg, rej_pend_reg, srej_pend_reg, rnr_pend_reg} <= 5'h0;
         {rr_pend_reg, rsnd_pend_reg, empty_pend_reg, rej_sent_reg} <= 4'h0;
         {sbuf_vld_reg, dlv2_reg, dlv_valid_reg, link_reset_reg} <= 4'h0;
         {tx_valid_reg, tx_empty_reg, tx_cfg_reg, tx_srej_reg} <= 4'h0;
         sbuf_tag_reg <= 8'h00;
         dlv_tag_reg <= 8'h00;
         tx_ctrl_reg <= 8'h00;
         tx_tag_reg <= 8'h00;
         tx_win_reg <= `SEQ_ZERO;
         tmr_rst_reg <= {`NTMR{1'b0}};
      end else begin
         link_reset_reg <= 1'b0;
         dlv_valid_reg <= 1'b0;
         dlv2_reg <= 1'b0;
         tmr_rst_reg <= {`NTMR{1'b0}};
         busy_q_reg <= local_busy_i;
         if (tx_valid_reg && tx_ready_i) begin
            tx_valid_reg <= 1'b0;
         end
         // Transmit selector: one frame is held until the framer takes it.
         if (tx_free) begin
            tx_empty_reg <= 1'b0;
            tx_cfg_reg <= 1'b0;
            if (ua_pend_reg) begin
               tx_valid_reg <= 1'b1;
               tx_ctrl_reg <= {`U_TAG, `U_UA};
               ua_pend_reg <= 1'b0;
            end else if (rset_pend_reg) begin
               tx_valid_reg <= 1'b1;
               tx_ctrl_reg <= {`U_TAG, `U_RSET};
               tx_cfg_reg <= 1'b1;
               tx_win_reg <= cfg_win_i;
               tx_srej_reg <= cfg_srej_i;
               rset_pend_reg <= 1'b0;
               tmr_rst_reg[`TMR_CON] <= 1'b1;
            end else if (is_up && (rej_pend_reg || srej_pend_reg || rnr_pend_reg || rr_pend_reg)) begin
               tx_valid_reg <= 1'b1;
               ack_run_reg <= 1'b0;
               if (rej_pend_reg) begin
                  tx_ctrl_reg <= {`S_TAG, `S_REJ, vr_reg};
                  rej_pend_reg <= 1'b0;
               end else if (srej_pend_reg) begin
                  tx_ctrl_reg <= {`S_TAG, `S_SREJ, vr_reg};
                  srej_pend_reg <= 1'b0;
               end else if (rnr_pend_reg || local_busy_i) begin
                  tx_ctrl_reg <= {`S_TAG, `S_RNR, vr_reg};
                  rnr_pend_reg <= 1'b0;
                  rr_pend_reg <= 1'b0;
               end else begin
                  tx_ctrl_reg <= {`S_TAG, `S_RR, vr_reg};
                  rr_pend_reg <= 1'b0;
                  tmr_rst_reg[`TMR_RR] <= 1'b1;
               end
            end else if (is_up && rsnd_pend_reg) begin
               tx_valid_reg <= 1'b1;
               tx_ctrl_reg <= {`I_TAG, rsnd_n_reg, vr_reg};
               tx_tag_reg <= q_tag[rsnd_n_reg];
               tx_empty_reg <= q_emp[rsnd_n_reg];
               rsnd_pend_reg <= 1'b0;
               ack_run_reg <= 1'b0;
               tmr_rst_reg[`TMR_GRD] <= 1'b1;
            end else if (is_up && ns_reg != head_reg && !peer_busy_reg) begin
               tx_valid_reg <= 1'b1;
               tx_ctrl_reg <= {`I_TAG, ns_reg, vr_reg};
               tx_tag_reg <= q_tag[ns_reg];
               tx_empty_reg <= q_emp[ns_reg];
               ns_reg <= ns_reg + `SEQ_ONE;
               ack_run_reg <= 1'b0;
               tmr_rst_reg[`TMR_GRD] <= 1'b1;
            end
         end
         if (ack_adv) begin
            tmr_rst_reg[`TMR_GRD] <= 1'b1;
         end
         // Timer consequences; pending flags are set after the selector clears them.
         if (tmr_exp[`TMR_ACK] || tmr_exp[`TMR_RR]) begin
            rr_pend_reg <= 1'b1;
         end
         if (tmr_exp[`TMR_GRD]) begin
            ns_reg <= dnr_reg;
         end
         if (tmr_exp[`TMR_CON]) begin
            rset_pend_reg <= 1'b1;
         end
         if (local_busy_i && !busy_q_reg) begin
            rnr_pend_reg <= 1'b1;
         end
         if (!local_busy_i && busy_q_reg) begin
            rr_pend_reg <= 1'b1;
            resume_reg <= 1'b1;
         end
         // Upper-layer queue; an empty frame only fills a slot nobody else wants.
         if (push) begin
            head_reg <= head_reg + `SEQ_ONE;
            empty_pend_reg <= 1'b0;
         end else if (empty_pend_reg && room) begin
            head_reg <= head_reg + `SEQ_ONE;
            empty_pend_reg <= 1'b0;
         end
         if (dlv2_reg) begin
            dlv_valid_reg <= 1'b1;
            dlv_tag_reg <= sbuf_tag_reg;
            vr_reg <= vr_nx;
            sbuf_vld_reg <= 1'b0;
         end
         // Receive handling.
         if (is_rset) begin
            if (rset_ok) begin
               ua_pend_reg <= 1'b1;
               st_reg <= `ST_UP;
               win_reg <= off_win;
               srej_neg_reg <= rx_srej_i && cfg_srej_i;
            end else begin
               rset_pend_reg <= 1'b1;
               st_reg <= `ST_WAIT;
            end
         end else if (is_ua && st_reg == `ST_WAIT) begin
            st_reg <= `ST_UP;
            win_reg <= cfg_win_i;
            srej_neg_reg <= cfg_srej_i;
         end else if (is_up) begin
            if (ack_ok && acks) begin
               dnr_reg <= rx_nr;
            end
            if (rx_i) begin
               resume_reg <= 1'b0;
               if (rx_ns == vr_reg) begin
                  dlv_valid_reg <= 1'b1;
                  dlv_tag_reg <= rx_tag_i;
                  vr_reg <= vr_nx;
                  rej_sent_reg <= 1'b0;
                  ack_run_reg <= 1'b1;
                  if (sbuf_vld_reg && sbuf_n_reg == vr_nx) begin
                     dlv2_reg <= 1'b1;
                  end
               end else if (srej_neg_reg && rx_ns == vr_nx && !sbuf_vld_reg) begin
                  sbuf_vld_reg <= 1'b1;
                  sbuf_n_reg <= rx_ns;
                  sbuf_tag_reg <= rx_tag_i;
                  srej_pend_reg <= 1'b1;
               end else if (!rej_sent_reg && !sbuf_vld_reg) begin
                  rej_pend_reg <= 1'b1;
                  rej_sent_reg <= 1'b1;
               end
            end else if (rx_s) begin
               case (rx_ty)
                  `S_RR: begin
                     peer_busy_reg <= 1'b0;
                     if (peer_busy_reg && ns_reg == head_reg && !push) begin
                        empty_pend_reg <= 1'b1;
                     end
                  end
                  `S_REJ: begin
                     peer_busy_reg <= 1'b0;
                     if (ack_ok) begin
                        ns_reg <= rx_nr;
                     end
                  end
                  `S_RNR: begin
                     peer_busy_reg <= 1'b1;
                  end
                  default: begin
                     rsnd_pend_reg <= 1'b1;
                     rsnd_n_reg <= rx_nr;
                  end
               endcase
            end
         end
         if (link_start_i) begin
            st_reg <= `ST_WAIT;
            rset_pend_reg <= 1'b1;
            ua_pend_reg <= 1'b0;
         end
         if (go_up || link_start_i) begin
            ns_reg <= `SEQ_ZERO;
            vr_reg <= `SEQ_ZERO;
            dnr_reg <= `SEQ_ZERO;
            head_reg <= `SEQ_ZERO;
            sbuf_vld_reg <= 1'b0;
            {rej_pend_reg, srej_pend_reg, rnr_pend_reg, rr_pend_reg} <= 4'h0;
            {rsnd_pend_reg, empty_pend_reg, rej_sent_reg, dlv2_reg} <= 4'h0;
            {ack_run_reg, peer_busy_reg, resume_reg, dlv_valid_reg} <= 4'h0;
            link_reset_reg <= 1'b1;
         end
      end
   end
   // Queue slots hold only handles; the payload stays with the framer.
   always @(posedge clk_sys_i) begin
      if (push) begin
         q_tag[head_reg] <= up_tag_i;
         q_emp[head_reg] <= 1'b0;
      end else if (empty_pend_reg && room) begin
         q_tag[head_reg] <= 8'h00;
         q_emp[head_reg] <= 1'b1;
      end
   end
   assign up_ready_o = room && !link_start_i;
   assign tx_valid_o = tx_valid_reg;
   assign tx_ctrl_o = tx_ctrl_reg;
   assign tx_tag_o = tx_tag_reg;
   assign tx_empty_o = tx_empty_reg;
   assign tx_cfg_o = tx_cfg_reg;
   assign tx_win_o = tx_win_reg;
   assign tx_srej_o = tx_srej_reg;
   assign dlv_valid_o = dlv_valid_reg;
   assign dlv_tag_o = dlv_tag_reg;
   assign link_up_o = is_up;
   assign link_reset_o = link_reset_reg;
endmodule
`default_nettype wire

// ---- src/shdlc_link_regs.vh ----
// Constants of the sliding-window link endpoint.
`ifndef SHDLC_LINK_REGS_VH
`define SHDLC_LINK_REGS_VH
// ****************************************
// Clock and times
// ****************************************
`define CLK_MHZ 100
`define T1_US 5000
`define T2_US 10000
`define T3_US 5000
`define TRR_US 10000
`define TMR_W 24
`define NTMR 4
`define TMR_ACK 0
`define TMR_GRD 1
`define TMR_CON 2
`define TMR_RR 3
// ****************************************
// Window and sequence numbers
// ****************************************
`define DEF_WIN 3'h4
`define SEQ_ZERO 3'h0
`define SEQ_ONE 3'h1
// ****************************************
// Control byte coding and link states
// ****************************************
`define I_TAG 2'h2
`define S_TAG 3'h6
`define U_TAG 3'h7
`define S_RR 2'h0
`define S_REJ 2'h1
`define S_RNR 2'h2
`define S_SREJ 2'h3
`define U_RSET 5'h19
`define U_UA 5'h06
`define ST_DOWN 2'h0
`define ST_WAIT 2'h1
`define ST_UP 2'h2
`endif

// ---- src/shdlc_link_endpoint_end.v ----
// Spare design file; all endpoint logic lives in the main design file.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ---- bench/peer_model.sv ----
// Peer endpoint model: takes frames from the endpoint, promptly or with stalls.
`timescale 1ns/1ns
`default_nettype none
module peer_model (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic slow_i,
   output logic tx_ready_o
);
   // *****
   // Frame acceptance
   // *****
   // Random stalls make the endpoint hold each frame until it is taken.
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_ready_o <= 1'b0;
      end else begin
         tx_ready_o <= slow_i ? ($urandom_range(1, 0) == 1) : 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- bench/shdlc_link_checker.sv ----
// Port assertions for the link endpoint.
`timescale 1ns/1ns
`default_nettype none
module shdlc_link_checker #(
   parameter int T1_CYC = 400
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic link_start_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_ctrl_i,
   input wire logic up_ready_o,
   input wire logic tx_valid_o,
   input wire logic [7:0] tx_ctrl_o,
   input wire logic dlv_valid_o,
   input wire logic link_up_o,
   input wire logic link_reset_o
);
   // *****
   // Properties
   // *****
   localparam int ACK_MAX = T1_CYC + 8;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   property p_start_ind;
      link_start_i |=> link_reset_o;
   endproperty
   a_start_ind: assert property (p_start_ind) else $error("no reset indication");
   property p_start_rset;
      link_start_i |-> ##[1:40] (tx_valid_o && tx_ctrl_o == 8'hf9);
   endproperty
   a_start_rset: assert property (p_start_rset) else $error("no RSET after start");
   property p_start_down;
      link_start_i |=> !link_up_o;
   endproperty
   a_start_down: assert property (p_start_down) else $error("link stayed up");
   property p_ind_pulse;
      link_reset_o |=> !link_reset_o;
   endproperty
   a_ind_pulse: assert property (p_ind_pulse) else $error("indication too long");
   property p_down_ready;
      !link_up_o |-> !up_ready_o;
   endproperty
   a_down_ready: assert property (p_down_ready) else $error("ready while down");
   property p_dlv_up;
      dlv_valid_o |-> link_up_o;
   endproperty
   a_dlv_up: assert property (p_dlv_up) else $error("delivery while down");
   property p_up_cause;
      $rose(link_up_o) |-> link_reset_o && $past(rx_valid_i);
   endproperty
   a_up_cause: assert property (p_up_cause) else $error("bad establishment");
   property p_ack_time;
      rx_valid_i && rx_ctrl_i[7:6] == 2'h2 && link_up_o |-> ##[1:ACK_MAX] tx_valid_o;
   endproperty
   a_ack_time: assert property (p_ack_time) else $error("no answer to frame");
   c_start: cover property (link_start_i);
   c_rset_up: cover property (rx_valid_i && rx_ctrl_i == 8'hf9 && link_up_o);
   c_sframe: cover property (tx_valid_o && tx_ctrl_o[7:5] == 3'h6);
endmodule
bind shdlc_link_endpoint shdlc_link_checker #(.T1_CYC(T1_CYC)) checker_inst (
   .clk_sys_i(clk_sys_i),
   .nrst_i(nrst_i),
   .link_start_i(link_start_i),
   .rx_valid_i(rx_valid_i),
   .rx_ctrl_i(rx_ctrl_i),
   .up_ready_o(up_ready_o),
   .tx_valid_o(tx_valid_o),
   .tx_ctrl_o(tx_ctrl_o),
   .dlv_valid_o(dlv_valid_o),
   .link_up_o(link_up_o),
   .link_reset_o(link_reset_o)
);
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the link endpoint against a peer model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   // *****
   // Signals and helpers
   // *****
   logic clk_sys_i, nrst_i, link_start_i, local_busy_i, rx_valid_i, up_valid_i, slow;
   logic cfg_srej_i, rx_has_cfg_i, rx_srej_i, hold_v, emp_exp, rs;
   logic tx_ready_i;
   logic [2:0] cfg_win_i, rx_win_i;
   logic [7:0] rx_ctrl_i, rx_tag_i, up_tag_i, tg, held;
   wire up_ready_o, tx_valid_o, tx_empty_o, tx_cfg_o, tx_srej_o, dlv_valid_o;
   wire link_up_o, link_reset_o;
   wire [7:0] tx_ctrl_o, tx_tag_o, dlv_tag_o;
   wire [2:0] tx_win_o;
   int bad_count, n_checks;
   logic [16:0] txq[$], e, sc;
   logic [7:0] dlq[$];
   shdlc_link_endpoint #(.T1_CYC(24'h190), .T2_CYC(24'h3e8), .T3_CYC(24'h1f4),
      .TRR_CYC(24'h320)) shdlc_link_endpoint_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .link_start_i(link_start_i), .cfg_win_i(cfg_win_i), .cfg_srej_i(cfg_srej_i),
      .local_busy_i(local_busy_i), .rx_valid_i(rx_valid_i), .rx_ctrl_i(rx_ctrl_i),
      .rx_tag_i(rx_tag_i), .rx_has_cfg_i(rx_has_cfg_i), .rx_win_i(rx_win_i),
      .rx_srej_i(rx_srej_i), .up_valid_i(up_valid_i), .up_tag_i(up_tag_i),
      .up_ready_o(up_ready_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
      .tx_ctrl_o(tx_ctrl_o), .tx_tag_o(tx_tag_o), .tx_empty_o(tx_empty_o),
      .tx_cfg_o(tx_cfg_o), .tx_win_o(tx_win_o), .tx_srej_o(tx_srej_o),
      .dlv_valid_o(dlv_valid_o), .dlv_tag_o(dlv_tag_o), .link_up_o(link_up_o),
      .link_reset_o(link_reset_o));
   peer_model peer_model_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .slow_i(slow),
      .tx_ready_o(tx_ready_i));
   task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Every frame taken by the peer must be the oldest expected one.
   always @(posedge clk_sys_i) begin
      if (nrst_i && tx_valid_o && tx_ready_i) begin
         e = txq.size() > 0 ? txq.pop_front() : 17'h1ffff;
         check("tx_frame", {e[16], tx_ctrl_o, e[16] ? tx_tag_o : 8'h00}, e);
         check("tx_empty", {16'h0, tx_empty_o}, {16'h0, e[16] && emp_exp});
         rs = (e[15:8] == 8'hf9);
         sc = {12'h0, tx_cfg_o, tx_cfg_o ? {tx_win_o, tx_srej_o} : 4'h0};
         check("tx_cfg", sc, {12'h0, rs, rs ? {cfg_win_i, cfg_srej_i} : 4'h0});
      end
      if (nrst_i && dlv_valid_o) begin
         e = dlq.size() > 0 ? {9'h0, dlq.pop_front()} : 17'h1ffff;
         check("dlv_tag", {9'h0, dlv_tag_o}, e);
      end
   end
   task automatic rx(input logic [7:0] c, input bit dl);
      tg = 8'($urandom());
      if (dl) begin
         dlq.push_back(tg);
      end
      // A frame parked out of order is delivered right after the one that fills the gap.
      if (hold_v) begin
         dlq.push_back(held);
         hold_v = 1'b0;
      end
      rx_ctrl_i <= c;
      rx_tag_i <= tg;
      rx_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      rx_valid_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
   endtask
   task automatic ready_is(input logic v);
      @(negedge clk_sys_i);
      check("up_ready", {16'h0, up_ready_o}, {16'h0, v});
      @(posedge clk_sys_i);
   endtask
   task automatic send(input logic [7:0] c);
      ready_is(1'b1);
      tg = 8'($urandom());
      up_tag_i <= tg;
      up_valid_i <= 1'b1;
      txq.push_back({1'b1, c, tg});
      @(posedge clk_sys_i);
      up_valid_i <= 1'b0;
   endtask
   task automatic drain(input int lim);
      @(posedge clk_sys_i);
      for (int i = 0; i < lim && txq.size() + dlq.size() > 0; i++) @(posedge clk_sys_i);
      check("pending", 17'(txq.size() + dlq.size()), 17'h0);
      if (txq.size() + dlq.size() > 0) begin
         results();
      end
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // *****
   // Scenarios
   // *****
   initial begin
      {nrst_i, link_start_i, local_busy_i, rx_valid_i, up_valid_i, slow, hold_v, emp_exp} = 8'h0;
      {cfg_srej_i, rx_has_cfg_i, rx_srej_i, rx_win_i} = 6'h0;
      held = 8'h00;
      {rx_ctrl_i, rx_tag_i, up_tag_i} = 24'h0;
      cfg_win_i = 3'h4;
      bad_count = 0;
      n_checks = 0;
      void'($urandom(16));
      repeat (5) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      @(posedge clk_sys_i);
      rx(8'h80, 1'b0);
      check("link_up", {16'h0, link_up_o}, 17'h0);
      link_start_i <= 1'b1;
      txq.push_back(17'h0f900);
      txq.push_back(17'h0f900);
      @(posedge clk_sys_i);
      link_start_i <= 1'b0;
      drain(800);
      rx(8'he6, 1'b0);
      check("link_up", {16'h0, link_up_o}, 17'h1);
      $display("test bring_up done");
      slow <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         send({2'h2, 3'(k), 3'h0});
         if (k % 4 == 3) begin
            ready_is(1'b0);
            drain(100);
            rx(k == 3 ? 8'hc4 : 8'hc0, 1'b0);
         end
      end
      $display("test window done");
      rx(8'h80, 1'b1);
      rx(8'h88, 1'b1);
      txq.push_back(17'h0c200);
      drain(700);
      txq.push_back(17'h0ca00);
      rx(8'h98, 1'b0);
      drain(10);
      txq.push_back(17'h0c300);
      rx(8'h90, 1'b1);
      drain(700);
      $display("test ack_reject done");
      send(8'h83);
      txq.push_back({1'b1, 8'h83, tg});
      repeat (850) @(posedge clk_sys_i);
      check("early_resend", 17'(txq.size()), 17'h1);
      drain(400);
      rx(8'hc1, 1'b0);
      $display("test guard done");
      local_busy_i <= 1'b1;
      txq.push_back(17'h0d300);
      drain(50);
      local_busy_i <= 1'b0;
      txq.push_back(17'h0c300);
      txq.push_back(17'h0c300);
      drain(1200);
      txq.push_back(17'h0c400);
      rx(8'h99, 1'b1);
      drain(700);
      $display("test busy done");
      txq.push_back(17'h0e600);
      rx(8'hf9, 1'b0);
      drain(50);
      check("link_up", {16'h0, link_up_o}, 17'h1);
      cfg_win_i <= 3'h2;
      txq.push_back(17'h0f900);
      rx(8'hf9, 1'b0);
      drain(50);
      check("link_up", {16'h0, link_up_o}, 17'h0);
      rx(8'he6, 1'b0);
      send(8'h80);
      send(8'h88);
      ready_is(1'b0);
      drain(100);
      rx(8'hc2, 1'b0);
      repeat (50) @(posedge clk_sys_i);
      $display("test renegotiate done");
      rx(8'hd2, 1'b0);
      send(8'h90);
      repeat (20) @(posedge clk_sys_i);
      check("suspended", 17'(txq.size()), 17'h1);
      rx(8'hc2, 1'b0);
      drain(100);
      rx(8'hc3, 1'b0);
      rx(8'hd3, 1'b0);
      emp_exp = 1'b1;
      txq.push_back(17'h19800);
      rx(8'hc3, 1'b0);
      drain(100);
      emp_exp = 1'b0;
      rx(8'hc4, 1'b0);
      $display("test peer_busy done");
      cfg_srej_i <= 1'b1;
      rx_has_cfg_i <= 1'b1;
      rx_win_i <= 3'h2;
      rx_srej_i <= 1'b1;
      txq.push_back(17'h0e600);
      rx(8'hf9, 1'b0);
      drain(50);
      rx(8'h80, 1'b1);
      txq.push_back(17'h0d900);
      rx(8'h90, 1'b0);
      held = tg;
      hold_v = 1'b1;
      rx(8'h88, 1'b1);
      drain(100);
      send(8'h83);
      held = tg;
      send(8'h8b);
      drain(100);
      txq.push_back({1'b1, 8'h83, held});
      rx(8'hd8, 1'b0);
      drain(100);
      rx(8'hc2, 1'b0);
      repeat (20) @(posedge clk_sys_i);
      $display("test selective done");
      results();
   end
endmodule
`default_nettype wire
